/* logic/lsd_pkg.sv */
// Shared constants, types and reset state for the LED scan decoder
package lsd_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int DIGIT_ON_US = 320;
   localparam int BLANK_US = 10;
   localparam int BLANK_MIN_US = 2;
   localparam int DIGIT_CYC = DIGIT_ON_US * CLK_MHZ;
   localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
   localparam int BLANK_MIN_CYC = BLANK_MIN_US * CLK_MHZ;
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_CTRL = 6'h00;
   localparam logic [5:0] OFF_DATA = 6'h04;
   localparam logic [5:0] OFF_RAND = 6'h08;
   localparam logic [5:0] OFF_CFG = 6'h0c;
   localparam logic [5:0] OFF_STAT = 6'h10;
   localparam int CB_BURST = 7;
   localparam int CB_FONT = 6;
   localparam int CB_DECODE = 5;
   localparam int CB_RUN = 4;
   localparam int CB_BANK = 3;
   localparam int RA_ADDR_LSB = 8;
   localparam int CFG_RAND = 0;
   localparam int CFG_FMT_LSB = 1;
   localparam logic [1:0] FMT_LOW = 2'h0;
   localparam logic [1:0] FMT_MID = 2'h1;
   localparam logic [1:0] FMT_HIGH = 2'h2;
   localparam logic [7:0] CTRL_RST = 8'h30;
   localparam logic [2:0] CFG_RST = 3'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Bus and display carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } lsd_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } lsd_axi_rsp_t;

   typedef struct packed {
      logic [7:0] digit_on;
      logic [6:0] seg;
      logic decimal_point_drive;
      logic blank;
   } lsd_disp_t;

   // ----------------------------------------------------------------
   // Block state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SC_OFF, SC_BLANK, SC_DRIVE} lsd_scan_t;

   typedef struct packed {
      logic aw_ok;
      logic [ADDR_W-1:0] aw_addr;
      logic w_ok;
      logic [10:0] w_data;
      logic [1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [15:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ctrl;
      logic [2:0] cfg;
      logic [7:0][7:0] ram;
      logic [7:0][3:0] bank_b;
      logic [7:0] dec_flag;
      logic burst_on;
      logic [2:0] burst_cnt;
      lsd_scan_t scan;
      logic [2:0] pos;
      logic [CNT_W-1:0] cnt;
      lsd_disp_t disp;
   } lsd_state_t;

   localparam lsd_state_t ST_RST = '{
      scan: SC_OFF,
      ctrl: CTRL_RST,
      cfg: CFG_RST,
      disp: '{blank: 1'b1, default: '0},
      default: '0
   };

endpackage

/* logic/lsd_scan_decoder.sv */
// Eight-digit LED scan decoder with display RAM behind an AXI4-Lite slave
//
// Overview of operation
// - Next data write stores byte at digit
// - Control bits 2:0 pick digit 1..8
// - Per-digit decode flag; one shared font
// - Control bits 4..6 set run/decode/font
// - Decoded: low nibble glyph, bit 7 point
// - Raw mode maps each bit to segment
// - One lights segment; point lights on zero
// - Random variant: address plus data write
// - Random variant: format pin, no raw mode
// - Shutdown stops scan, drivers off, writes kept
// - Control bit 4 low means shutdown
// - FF in font B, 80 raw blank
// - Each digit driven about 320 us
// - Blanking of 10 us between digits
// - Scan order 2,5,1,7,8,6,4,3
// - Blanking held active during shutdown
// - Data captured on completed write
// - Burst load: blank, eight writes, resume
// - Two nibble banks, shared point, decoded only
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

module lsd_scan_decoder #(
   parameter int DIGIT_CYCLES = lsd_pkg::DIGIT_CYC,
   parameter int BLANK_CYCLES = lsd_pkg::BLANK_CYC,
   parameter logic [41:0] HEX_HI_GLYPHS = {7'h47, 7'h4f, 7'h3d, 7'h4e, 7'h1f, 7'h77},
   parameter logic [41:0] CODEB_HI_GLYPHS = {7'h00, 7'h67, 7'h0e, 7'h37, 7'h4f, 7'h01}
) (
   input logic aclk,
   input logic aresetn,
   input lsd_pkg::lsd_axi_req_t axi_req,
   output lsd_pkg::lsd_axi_rsp_t axi_rsp,
   output lsd_pkg::lsd_disp_t disp
);
   import lsd_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (DIGIT_CYCLES < 2 || DIGIT_CYCLES >= (1 << CNT_W)) begin : g_bad_digit
      $error("DIGIT_CYCLES out of range");
   end
   if (BLANK_CYCLES < BLANK_MIN_CYC || BLANK_CYCLES >= (1 << CNT_W)) begin : g_bad_blank
      $error("BLANK_CYCLES out of range");
   end
   if (CODEB_HI_GLYPHS[41:35] != 7'h00) begin : g_bad_glyph
      $error("Code 1111 in font B must be dark");
   end

   // ----------------------------------------------------------------
   // Constant tables
   // ----------------------------------------------------------------
   // Numerals 0..9, segments a..g from bit 6 down to bit 0
   localparam logic [69:0] NUM_GLYPHS = {
      7'h7b, 7'h7f, 7'h70, 7'h5f, 7'h5b,
      7'h33, 7'h79, 7'h6d, 7'h30, 7'h7e
   };
   // Scan slot to digit index, slot 0 in the low bits
   localparam logic [23:0] SCAN_ORDER = {
      3'h2, 3'h3, 3'h5, 3'h7, 3'h6, 3'h0, 3'h4, 3'h1
   };
   localparam logic [CNT_W-1:0] DIG_LAST = CNT_W'(DIGIT_CYCLES - 1);
   localparam logic [CNT_W-1:0] BLK_LAST = CNT_W'(BLANK_CYCLES - 1);

   lsd_state_t q;
   lsd_state_t d;

   // ----------------------------------------------------------------
   // Segment decoder: returns {point_on, a..g}
   // ----------------------------------------------------------------
   function automatic logic [7:0] glyph(
      input logic [7:0] b,
      input logic [3:0] nb,
      input logic dec,
      input logic hex,
      input logic bk
   );
      logic [3:0] c;
      logic [6:0] s;
      // Bank B nibble only reaches decoded digits, the point is shared
      c = bk ? nb : b[3:0];
      if (!dec) begin
         s = {b[6], b[5], b[4], b[0], b[3], b[1], b[2]};
      end else if (c < 4'ha) begin
         s = NUM_GLYPHS[c*7 +: 7];
      end else if (hex) begin
         s = HEX_HI_GLYPHS[(c - 4'ha)*7 +: 7];
      end else begin
         s = CODEB_HI_GLYPHS[(c - 4'ha)*7 +: 7];
      end
      glyph = {~b[7], s};
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      // Bus and store scratch
      logic aw_hs;
      logic w_hs;
      logic have_aw;
      logic have_w;
      logic [ADDR_W-1:0] wa;
      logic [10:0] wd;
      logic [1:0] ws;
      logic [2:0] tgt;
      logic do_store;
      // Display scratch
      logic rnd;
      logic shut;
      logic hex;
      logic bank;
      logic [2:0] dig;
      logic [7:0] g;

      aw_hs = 1'b0;
      w_hs = 1'b0;
      have_aw = 1'b0;
      have_w = 1'b0;
      wa = '0;
      wd = '0;
      ws = '0;
      tgt = '0;
      do_store = 1'b0;
      rnd = 1'b0;
      shut = 1'b0;
      hex = 1'b0;
      bank = 1'b0;
      dig = '0;
      g = '0;

      // Every field except disp holds unless a branch below changes it; disp is rebuilt every cycle
      d = q;

      // Bus handshakes; address and data may come in either order
      aw_hs = axi_req.awvalid && !q.aw_ok && !q.bvalid;
      w_hs = axi_req.wvalid && !q.w_ok && !q.bvalid;
      have_aw = q.aw_ok || aw_hs;
      have_w = q.w_ok || w_hs;
      wa = q.aw_ok ? q.aw_addr : axi_req.awaddr;
      wd = q.w_ok ? q.w_data : axi_req.wdata[10:0];
      ws = q.w_ok ? q.w_strb : axi_req.wstrb[1:0];
      if (aw_hs) begin
         d.aw_ok = 1'b1;
         d.aw_addr = axi_req.awaddr;
      end
      if (w_hs) begin
         d.w_ok = 1'b1;
         d.w_data = axi_req.wdata[10:0];
         d.w_strb = axi_req.wstrb[1:0];
      end
      // Response accepted by the master
      if (q.bvalid && axi_req.bready) begin
         d.bvalid = 1'b0;
      end

      // Register writes, committed once both halves are held
      rnd = q.cfg[CFG_RAND];
      if (have_aw && have_w && !q.bvalid) begin
         d.aw_ok = 1'b0;
         d.w_ok = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         unique case ({wa[ADDR_W-1:2], 2'b00})
            OFF_CTRL: begin
               if (ws[0] && !rnd) begin
                  d.ctrl = wd[7:0];
                  d.burst_on = wd[CB_BURST];
                  d.burst_cnt = '0;
               end
            end
            OFF_DATA: begin
               if (ws[0] && !rnd) begin
                  if (!q.ctrl[CB_BURST]) begin
                     tgt = q.ctrl[2:0];
                     do_store = 1'b1;
                  end else if (q.burst_on) begin
                     tgt = q.burst_cnt;
                     do_store = 1'b1;
                     d.burst_cnt = q.burst_cnt + 3'h1;
                     d.burst_on = (q.burst_cnt != 3'h7);
                  end
               end
            end
            OFF_RAND: begin
               if (ws == 2'h3 && rnd) begin
                  // Random variant: decoded nibble plus point only
                  tgt = wd[RA_ADDR_LSB +: 3];
                  d.ram[tgt][3:0] = wd[3:0];
                  d.ram[tgt][7] = wd[7];
                  d.dec_flag[tgt] = 1'b1;
               end
            end
            OFF_CFG: begin
               if (ws[0]) begin
                  d.cfg = wd[2:0];
               end
            end
            default: begin
               if (wa[ADDR_W-1:2] != OFF_STAT[ADDR_W-1:2]) begin
                  d.bresp = RESP_SLVERR;
               end
            end
         endcase
      end

      // Display RAM store for the sequential variant
      if (do_store) begin
         d.dec_flag[tgt] = q.ctrl[CB_DECODE];
         if (!q.ctrl[CB_DECODE]) begin
            d.ram[tgt] = wd[7:0];
         end else if (q.ctrl[CB_BANK]) begin
            d.bank_b[tgt] = wd[3:0];
            d.ram[tgt][7] = wd[7];
         end else begin
            d.ram[tgt][3:0] = wd[3:0];
            d.ram[tgt][7] = wd[7];
         end
      end

      // Register reads
      if (q.rvalid && axi_req.rready) begin
         d.rvalid = 1'b0;
      end
      if (axi_req.arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = '0;
         unique case ({axi_req.araddr[ADDR_W-1:2], 2'b00})
            OFF_CTRL: d.rdata[7:0] = q.ctrl;
            OFF_DATA: d.rdata = '0;
            OFF_RAND: d.rdata = '0;
            OFF_CFG: d.rdata[2:0] = q.cfg;
            OFF_STAT: begin
               // Slot, shutdown, blank, burst active, burst count
               d.rdata[2:0] = q.pos;
               d.rdata[3] = (q.scan == SC_OFF);
               d.rdata[4] = q.disp.blank;
               d.rdata[5] = q.burst_on;
               d.rdata[8:6] = q.burst_cnt;
            end
            default: d.rresp = RESP_SLVERR;
         endcase
      end

      // Effective format from the variant in use
      if (rnd) begin
         shut = (q.cfg[CFG_FMT_LSB +: 2] == FMT_LOW);
         hex = (q.cfg[CFG_FMT_LSB +: 2] >= FMT_HIGH);
         bank = 1'b0;
      end else begin
         shut = !q.ctrl[CB_RUN];
         hex = q.ctrl[CB_FONT];
         bank = q.ctrl[CB_BANK] && q.ctrl[CB_DECODE];
      end
      dig = SCAN_ORDER[q.pos*3 +: 3];
      g = glyph(q.ram[dig], q.bank_b[dig], rnd || q.dec_flag[dig], hex,
                bank && q.dec_flag[dig]);

      // Scan sequencer: blank gap, then drive one digit
      unique case (q.scan)
         SC_OFF: begin
            d.cnt = '0;
            if (!shut) begin
               d.scan = SC_BLANK;
            end
         end
         SC_BLANK: begin
            d.cnt = q.cnt + CNT_W'(1);
            if (q.cnt == BLK_LAST) begin
               d.cnt = '0;
               d.scan = SC_DRIVE;
            end
         end
         SC_DRIVE: begin
            d.cnt = q.cnt + CNT_W'(1);
            if (q.cnt == DIG_LAST) begin
               d.cnt = '0;
               d.scan = SC_BLANK;
               d.pos = q.pos + 3'h1;
            end
         end
         default: begin
            // Unused code: fall back to idle so the scan restarts cleanly
            d.scan = SC_OFF;
            d.cnt = '0;
         end
      endcase
      if (shut) begin
         d.scan = SC_OFF;
         d.cnt = '0;
      end

      // Driver outputs, dark in blanking, shutdown and burst load
      d.disp = '{blank: 1'b1, default: '0};
      if (d.scan == SC_DRIVE && !q.burst_on) begin
         d.disp.blank = 1'b0;
         d.disp.digit_on = 8'h01 << dig;
         d.disp.seg = g[6:0];
         d.disp.decimal_point_drive = g[7];
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Write channels: readies combinational, response from flops
   assign axi_rsp.awready = !q.aw_ok && !q.bvalid;
   assign axi_rsp.wready = !q.w_ok && !q.bvalid;
   assign axi_rsp.bvalid = q.bvalid;
   assign axi_rsp.bresp = q.bresp;

   // Read channels: upper data bits are always zero
   assign axi_rsp.arready = !q.rvalid;
   assign axi_rsp.rvalid = q.rvalid;
   assign axi_rsp.rdata = {16'h0000, q.rdata};
   assign axi_rsp.rresp = q.rresp;

   // Display drivers straight from the state register
   assign disp = q.disp;

endmodule

/* sim/led_display_scan_decoder_bench.sv */
// Self-checking bench for the LED scan decoder
`timescale 1ns/1ps

module led_display_scan_decoder_bench;
   import lsd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   lsd_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
   lsd_axi_rsp_t rsp;
   lsd_disp_t disp;
   logic new_q;
   logic [15:0] view;
   int mismatches = 0;
   int check_count = 0;
   logic [33:0] bq[$];
   logic [33:0] dq[$];
   logic [7:0] eg[8];
   int ord[8] = '{1, 4, 0, 6, 7, 5, 3, 2};
   logic [6:0] num[10] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70, 7'h7f, 7'h7b};
   logic [7:0] b;
   logic [3:0] c;
   logic p;

   lsd_scan_decoder #(.DIGIT_CYCLES(20), .BLANK_CYCLES(50)) i_lsd_scan_decoder (.aclk(aclk),
      .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .disp(disp));
   lsd_display_model i_lsd_display_model (.aclk(aclk), .disp(disp), .new_q(new_q),
      .view_q(view));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   always #20 aclk = ~aclk;

   task automatic print_verdict();
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask

   task automatic tmo();
      mismatches++;
      $display("BAD %0t timeout", $time);
      print_verdict();
   endtask

   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      bq.push_back({r, 32'h0});
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      do begin
         tick(n);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1 && n < 99);
      if (n >= 99) tmo();
   endtask

   task automatic rd(input logic [5:0] a, input logic [33:0] e);
      int n;
      n = 0;
      bq.push_back(e);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      do begin
         tick(n);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1 && n < 99);
      if (n >= 99) tmo();
   endtask

   // Expected glyph and point drive of a decoded digit
   function automatic logic [7:0] dec2(input logic [3:0] k, input logic dp, input logic hx);
      logic [6:0] g;
      g = 7'h00;
      if (k < 4'ha) g = num[k];
      else if (hx && k == 4'ha) g = 7'h77;
      else if (hx && k == 4'hf) g = 7'h47;
      return {g, ~dp};
   endfunction

   function automatic logic [7:0] raw2(input logic [7:0] v);
      return {v[6], v[5], v[4], v[0], v[3], v[1], v[2], ~v[7]};
   endfunction

   // Queue a full frame starting at digit 2, then let the monitor drain it
   task automatic show();
      int n;
      int i;
      n = 0;
      while (disp.digit_on !== 8'h04 && n < 3000) tick(n);
      while (disp.blank !== 1'b1 && n < 3000) tick(n);
      for (i = 0; i < 8; i++) dq.push_back({18'h0, 8'h01 << ord[i], eg[ord[i]]});
      while (dq.size() > 0 && n < 3000) tick(n);
      if (n >= 3000) tmo();
   endtask

   // Compare every bus answer, and each digit drive while frame notes are queued, with the oldest note
   always @(posedge aclk) begin
      if (rsp.bvalid === 1'b1) chk({rsp.bresp, 32'h0}, bq.pop_front());
      if (rsp.rvalid === 1'b1) chk({rsp.rresp, rsp.rdata}, bq.pop_front());
      if (new_q === 1'b1 && dq.size() > 0) chk({18'h0, view}, dq.pop_front());
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(1250));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_CTRL, {26'h0, CTRL_RST});
      rd(OFF_CFG, {31'h0, CFG_RST});
      rd(6'h14, {RESP_SLVERR, 32'h0});
      wr(6'h14, 32'h0, RESP_SLVERR);
      // Digit 1 raw, the rest decoded in font B, digit 8 blank code
      wr(OFF_CTRL, 32'h10, RESP_OKAY);
      b = 8'($urandom);
      wr(OFF_DATA, {24'h0, b}, RESP_OKAY);
      eg[0] = raw2(b);
      for (int i = 1; i < 7; i++) begin
         c = 4'($urandom % 10);
         p = 1'($urandom);
         wr(OFF_CTRL, 32'h30 | i, RESP_OKAY);
         wr(OFF_DATA, {24'h0, p, 3'h0, c}, RESP_OKAY);
         eg[i] = dec2(c, p, 1'b0);
      end
      wr(OFF_CTRL, 32'h37, RESP_OKAY);
      wr(OFF_DATA, 32'hff, RESP_OKAY);
      eg[7] = dec2(4'hf, 1'b1, 1'b0);
      show();
      // Font change reaches decoded digits only
      wr(OFF_CTRL, 32'h70, RESP_OKAY);
      eg[7] = dec2(4'hf, 1'b1, 1'b1);
      show();
      // Shutdown keeps drivers dark but still stores data
      wr(OFF_CTRL, 32'h00, RESP_OKAY);
      wr(OFF_DATA, 32'h80, RESP_OKAY);
      eg[0] = raw2(8'h80);
      repeat (60) @(posedge aclk);
      chk({25'h0, disp.blank, disp.digit_on}, 34'h100);
      wr(OFF_CTRL, 32'h70, RESP_OKAY);
      show();
      // Burst load of eight digits, a ninth write ignored
      wr(OFF_CTRL, 32'h90, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         b = 8'($urandom);
         wr(OFF_DATA, {24'h0, b}, RESP_OKAY);
         eg[i] = raw2(b);
      end
      wr(OFF_DATA, 32'h7f, RESP_OKAY);
      show();
      // Random-access variant in hex, then format pin low
      wr(OFF_CFG, 32'h5, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         c = (i == 7) ? 4'ha : 4'($urandom % 10);
         p = 1'($urandom);
         wr(OFF_RAND, {21'h0, i[2:0], p, 3'h0, c}, RESP_OKAY);
         eg[i] = dec2(c, p, 1'b1);
      end
      show();
      wr(OFF_CFG, 32'h1, RESP_OKAY);
      repeat (60) @(posedge aclk);
      chk({25'h0, disp.blank, disp.digit_on}, 34'h100);
      print_verdict();
   end
endmodule

/* sim/lsd_display_model.sv */
// Passive model of the multiplexed display that records each digit drive
`timescale 1ns/1ps

module lsd_display_model (
   input logic aclk,
   input lsd_pkg::lsd_disp_t disp,
   output logic new_q,
   output logic [15:0] view_q
);
   import lsd_pkg::*;
   logic [7:0] prev_q;
   // Flag the first cycle of every digit drive and latch what it shows
   always_ff @(posedge aclk) begin
      prev_q <= disp.digit_on;
      new_q <= (disp.digit_on != 8'h00) && (prev_q == 8'h00);
      view_q <= {disp.digit_on, disp.seg, disp.decimal_point_drive};
   end
endmodule

/* sim/lsd_scan_chk.sv */
// Port assertions for the LED scan decoder
`timescale 1ns/1ps

module lsd_scan_chk #(
   parameter int DIGIT_CYCLES = 8000,
   parameter int BLANK_CYCLES = 250
) (
   input logic aclk,
   input logic aresetn,
   input lsd_pkg::lsd_axi_req_t axi_req,
   input lsd_pkg::lsd_axi_rsp_t axi_rsp,
   input lsd_pkg::lsd_disp_t disp
);
   import lsd_pkg::*;
   logic [15:0] bc_q;
   logic [15:0] dc_q;
   logic [7:0] last_q;
   // Successor of a digit in the scan sequence
   function automatic logic [7:0] nxt(input logic [7:0] d);
      case (d)
         8'h02: nxt = 8'h10;
         8'h10: nxt = 8'h01;
         8'h01: nxt = 8'h40;
         8'h40: nxt = 8'h80;
         8'h80: nxt = 8'h20;
         8'h20: nxt = 8'h08;
         8'h08: nxt = 8'h04;
         default: nxt = 8'h02;
      endcase
   endfunction
   // Run lengths of blank and drive; last digit forgotten after a long pause
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bc_q <= '0;
         dc_q <= '0;
         last_q <= '0;
      end else begin
         bc_q <= disp.blank ? bc_q + 16'h1 : 16'h0;
         dc_q <= disp.blank ? 16'h0 : dc_q + 16'h1;
         if (!disp.blank) last_q <= disp.digit_on;
         else if (bc_q > BLANK_CYCLES) last_q <= '0;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_blank_dark: assert property (disp.blank |-> disp.digit_on == 8'h00 &&
      disp.seg == 7'h00 && !disp.decimal_point_drive) else $error("drivers on in blank");
   a_one_digit: assert property (!disp.blank |-> $onehot(disp.digit_on))
      else $error("digit drive not one-hot");
   a_gap_length: assert property (!disp.blank && $past(disp.blank) |->
      bc_q >= BLANK_CYCLES) else $error("blanking gap too short");
   a_scan_order: assert property (!disp.blank && $past(disp.blank) &&
      last_q != 8'h00 |-> disp.digit_on == nxt(last_q)) else $error("scan order wrong");
   a_drive_length: assert property (!disp.blank |-> dc_q < DIGIT_CYCLES)
      else $error("digit driven too long");
   // Segments may follow a committed write mid slot, the digit may not
   a_drive_steady: assert property (!disp.blank && !$past(disp.blank) |->
      $stable(disp.digit_on) && ($stable(disp.seg) || $past(axi_rsp.bvalid)))
      else $error("drive changed mid slot");
   a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
      axi_rsp.wready |=> axi_rsp.bvalid) else $error("no write response");
   a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("no read response");
   a_bad_addr: assert property (axi_req.arvalid && axi_rsp.arready &&
      axi_req.araddr[5:2] > OFF_STAT[5:2] |=> axi_rsp.rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
   a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
   c_order: cover property (!disp.blank && $past(disp.blank) && last_q != 8'h00);
   c_resume: cover property (!disp.blank && bc_q > BLANK_CYCLES);
   c_bad: cover property (axi_req.arvalid && axi_rsp.arready &&
      axi_req.araddr[5:2] > OFF_STAT[5:2]);
endmodule

bind lsd_scan_decoder lsd_scan_chk #(.DIGIT_CYCLES(DIGIT_CYCLES), .BLANK_CYCLES(BLANK_CYCLES))
   i_lsd_scan_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .disp(disp));
